/* sim/modulo_timer_bench.sv */
// modulo_timer_bench: self-checking apb testbench for the modulo timer
`timescale 1ns/100ps
`default_nettype none

module modulo_timer_bench;
  import modulo_timer_pkg::*;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        fixed_frequency_clock, external_timer_clock_pin, debug_halt_mode, overflow_irq;
  logic [2:0]  fdiv;
  logic [31:0] last_rd;
  logic [15:0] cnt;
  logic [7:0]  rnd;
  logic [32:0] note_q[$];
  logic [32:0] skip_q[$];
  int          bad_count, total_checks, seed, e;

  modulo_timer #(.COUNT_WIDTH(16)) modulo_timer_i (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fixed_frequency_clock(fixed_frequency_clock),
    .external_timer_clock_pin(external_timer_clock_pin),
    .debug_halt_mode(debug_halt_mode), .overflow_irq(overflow_irq)
  );

  always #10 pclk = ~pclk;

  // free-running fixed clock, one period every 8 bus cycles
  always @(posedge pclk) begin
    fdiv <= fdiv + 3'd1;
    fixed_frequency_clock <= fdiv[2];
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // one apb transfer; leaves one idle edge so psel is never set twice per step
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    psel    <= 1'b1;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      end_sim();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(a, 1'b1, {24'h0, d});
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] exp);
    note_q.push_back(exp);
    skip_q.push_back(33'h0);
    xfer(a, 1'b0, 32'h0);
  endtask

  // read without a fixed expectation; value lands in last_rd
  task automatic rdv(input logic [7:0] a);
    note_q.push_back(33'h0);
    skip_q.push_back(33'h1);
    xfer(a, 1'b0, 32'h0);
  endtask

  task automatic rd_count;
    rdv(OFS_COUNT_HIGH);
    cnt[15:8] = last_rd[7:0];
    rdv(OFS_COUNT_LOW);
    cnt[7:0] = last_rd[7:0];
  endtask

  task automatic wait_flag;
    int n;
    n = 0;
    do begin
      rdv(OFS_STATUS_CONTROL);
      n++;
    end while (last_rd[SC_FLAG_BIT] !== 1'b1 && n < 200);
    check({32'h0, last_rd[SC_FLAG_BIT]}, 33'h1);
    // a flag that never came means the rest of the run is meaningless
    if (last_rd[SC_FLAG_BIT] !== 1'b1) begin
      end_sim();
    end
  endtask

  task automatic pulses(input int k);
    repeat (k) begin
      external_timer_clock_pin <= 1'b1;
      wait_cyc(3);
      external_timer_clock_pin <= 1'b0;
      wait_cyc(3);
    end
  endtask

  // monitor: each completed read takes the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (note_q.size() == 0) begin
        check({pslverr, prdata}, 33'h1_dead_beef);
      end else if (skip_q.pop_front() == 33'h1) begin
        void'(note_q.pop_front());
        last_rd <= prdata;
      end else begin
        check({pslverr, prdata}, note_q.pop_front());
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    fdiv = 0; fixed_frequency_clock = 0; external_timer_clock_pin = 0; debug_halt_mode = 0;
    last_rd = 0; cnt = 0; bad_count = 0; total_checks = 0; seed = 48;
    wait_cyc(12);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFS_STATUS_CONTROL, 33'h10);
    rd(OFS_CLOCK_CONFIG, 33'h0);
    rd(OFS_COUNT_HIGH, 33'h0);
    rd(OFS_COUNT_LOW, 33'h0);
    rd(OFS_MODULO_HIGH, 33'h0);
    rd(OFS_MODULO_LOW, 33'h0);
    rd(8'h1c, 33'h1_0000_0000);
    // first completed modulo write applies at once
    wr(OFS_MODULO_HIGH, 8'h00);
    wr(OFS_MODULO_LOW, 8'h05);
    rd(OFS_MODULO_LOW, 33'h05);
    wr(OFS_STATUS_CONTROL, 8'h00);
    wait_flag();
    rd_count();
    check({32'h0, cnt <= 16'h5}, 33'h1);
    // overflow between the two clearing steps keeps the flag
    rd(OFS_STATUS_CONTROL, 33'h80);
    wait_cyc(12);
    wr(OFS_STATUS_CONTROL, 8'h00);
    rd(OFS_STATUS_CONTROL, 33'h80);
    wr(OFS_STATUS_CONTROL, 8'h90);
    rd(OFS_STATUS_CONTROL, 33'h90);
    wr(OFS_STATUS_CONTROL, 8'h10);
    rd(OFS_STATUS_CONTROL, 33'h10);
    // interrupt follows flag and enable
    wr(OFS_STATUS_CONTROL, 8'h50);
    wait_cyc(2);
    check({32'h0, overflow_irq}, 33'h0);
    wr(OFS_STATUS_CONTROL, 8'h40);
    e = 0;
    while (overflow_irq !== 1'b1 && e < 40) begin
      @(posedge pclk);
      e++;
    end
    check({32'h0, overflow_irq}, 33'h1);
    if (overflow_irq !== 1'b1) begin
      end_sim();
    end
    wr(OFS_STATUS_CONTROL, 8'h70);
    wait_cyc(2);
    check({32'h0, overflow_irq}, 33'h0);
    rd(OFS_STATUS_CONTROL, 33'h50);
    rd(OFS_COUNT_LOW, 33'h0);
    wr(OFS_STATUS_CONTROL, 8'h10);
    // buffered modulo waits for the second byte, then for the next cycle
    wr(OFS_MODULO_HIGH, 8'h00);
    rd(OFS_MODULO_LOW, 33'h05);
    wr(OFS_MODULO_LOW, 8'h02);
    rd(OFS_MODULO_LOW, 33'h05);
    wr(OFS_STATUS_CONTROL, 8'h00);
    wait_cyc(30);
    wr(OFS_STATUS_CONTROL, 8'h10);
    rd(OFS_MODULO_LOW, 33'h02);
    rd_count();
    check({32'h0, cnt <= 16'h2}, 33'h1);
    // counter reset restarts byte pairing
    wr(OFS_MODULO_HIGH, 8'h01);
    wr(OFS_STATUS_CONTROL, 8'h30);
    wr(OFS_MODULO_LOW, 8'h07);
    rd(OFS_MODULO_LOW, 33'h02);
    wr(OFS_MODULO_HIGH, 8'h00);
    wr(OFS_STATUS_CONTROL, 8'h30);
    rd(OFS_MODULO_LOW, 33'h07);
    // after software reset a completed write applies at once
    rnd = 8'($random(seed));
    wr(OFS_MODULO_HIGH, 8'h00);
    wr(OFS_MODULO_LOW, 8'h09);
    wr(OFS_SOFT_RESET, 8'h01);
    wr(OFS_MODULO_HIGH, 8'h00);
    wr(OFS_MODULO_LOW, rnd);
    rd(OFS_MODULO_LOW, {25'h0, rnd});
    // debug halt: direct byte writes clear the count, latch state frozen
    wr(OFS_MODULO_LOW, 8'h33);
    debug_halt_mode <= 1'b1;
    wr(OFS_STATUS_CONTROL, 8'h00);
    wait_cyc(40);
    wr(OFS_MODULO_HIGH, 8'h01);
    wr(OFS_STATUS_CONTROL, 8'h10);
    rd_count();
    check({32'h0, cnt <= 16'h8}, 33'h1);
    rd(OFS_MODULO_HIGH, 33'h01);
    debug_halt_mode <= 1'b0;
    wr(OFS_MODULO_HIGH, 8'h00);
    wr(OFS_STATUS_CONTROL, 8'h30);
    rd(OFS_MODULO_LOW, 33'h33);
    // prescaler codes 0..9 on the bus clock, free-running
    wr(OFS_MODULO_LOW, 8'h00);
    wr(OFS_MODULO_HIGH, 8'h00);
    wr(OFS_STATUS_CONTROL, 8'h30);
    rd(OFS_MODULO_LOW, 33'h0);
    for (int n = 0; n < 10; n++) begin
      wr(OFS_CLOCK_CONFIG, 8'(n));
      rd(OFS_CLOCK_CONFIG, 33'(n));
      wr(OFS_STATUS_CONTROL, 8'h20);
      wait_cyc(1024);
      wr(OFS_STATUS_CONTROL, 8'h10);
      rd_count();
      e = 1024 >> (n > 8 ? 8 : n);
      check({32'h0, (int'(cnt) + 1 >= e) && (int'(cnt) <= e + 6)}, 33'h1);
    end
    // fixed clock, then pin rising edges, then falling edges mid-run
    wr(OFS_CLOCK_CONFIG, 8'h10);
    wr(OFS_STATUS_CONTROL, 8'h20);
    wait_cyc(800);
    wr(OFS_STATUS_CONTROL, 8'h10);
    rd_count();
    check({32'h0, cnt >= 16'd98 && cnt <= 16'd102}, 33'h1);
    wr(OFS_CLOCK_CONFIG, 8'h30);
    wr(OFS_STATUS_CONTROL, 8'h20);
    pulses(20);
    wait_cyc(8);
    rd_count();
    check({17'h0, cnt}, 33'd20);
    wr(OFS_CLOCK_CONFIG, 8'h20);
    pulses(5);
    wait_cyc(8);
    wr(OFS_STATUS_CONTROL, 8'h10);
    rd_count();
    check({17'h0, cnt}, 33'd25);
    // prescale change while running: count carries on at the new rate
    wr(OFS_STATUS_CONTROL, 8'h00);
    wr(OFS_CLOCK_CONFIG, 8'h02);
    wait_cyc(40);
    wr(OFS_STATUS_CONTROL, 8'h10);
    rd_count();
    check({32'h0, cnt >= 16'd35 && cnt <= 16'd38}, 33'h1);
    // free-running wrap at the 16-bit maximum
    wr(OFS_CLOCK_CONFIG, 8'h00);
    wr(OFS_STATUS_CONTROL, 8'h20);
    wait_cyc(65500);
    rd(OFS_STATUS_CONTROL, 33'h00);
    wait_flag();
    rd(OFS_COUNT_HIGH, 33'h0);
    end_sim();
  end
endmodule

`default_nettype wire

/* verilog/modulo_timer.sv */
// modulo_timer: 16-bit prescaled modulo up-counter with apb register access
//
// Function
// - zero modulo means free-running, else modulo
// - modulo bytes buffered until second byte written
// - new modulo applies at next counter cycle
// - first write after chip reset: clear, apply
// - after software reset, completed write applies immediately
// - counter reset restarts modulo byte latching
// - debug halt freezes modulo latch state
// - debug writes go direct, clear counter
// - modulo reads return the active value
// - reset: stopped, zero count/modulo, bus clock, div1
// - four sources: bus, fixed, pin fall, pin rise
// - source change keeps count running
// - prescaler divides by one to 256
// - prescale change keeps count running
// - count up to modulo, roll to zero
// - flag sets on modulo-to-zero transition
// - flag clears by status read then zero write
// - overflow between steps restarts clear sequence
// - counter reset also clears the flag
// - interrupt when flag and enable both set
// - source code 00 bus,01 fixed,10 fall,11 rise
// - prescale code n divides by 2**n, max 256
// - stop bit set by reset holds count
`timescale 1ns/100ps
`default_nettype none

module modulo_timer #(
  parameter int unsigned COUNT_WIDTH = 16
) (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic [7:0]                   paddr,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [31:0]                  pwdata,
  output var  logic [31:0]                  prdata,
  output var  logic                         pready,
  output var  logic                         pslverr,
  input  wire logic                         fixed_frequency_clock,
  input  wire logic                         external_timer_clock_pin,
  input  wire logic                         debug_halt_mode,
  output var  logic                         overflow_irq
);
  import modulo_timer_pkg::*;

  generate
    if (COUNT_WIDTH != 16) begin : g_width_check
      $error("modulo_timer supports only a 16-bit counter");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  logic        xfer_done;
  logic        wr_done;
  logic        rd_done;
  logic        addr_ok;
  logic        wr_sc;
  logic        wr_cfg;
  logic        wr_mh;
  logic        wr_ml;
  logic        rd_sc;
  logic        trst;
  logic        soft_rst;
  logic [31:0] rd_mux;

  logic [15:0] cnt_reg;
  logic [15:0] mod_reg;
  logic [15:0] pend_reg;
  logic        pend_valid_reg;
  logic        imm_chip_reg;
  logic        imm_soft_reg;
  logic        flag_reg;
  logic        ie_reg;
  logic        stop_reg;
  clk_cfg_t    cfg_reg;
  mod_latch_t  latch_reg;
  clr_state_t  clr_state_reg;

  // a transfer completes at the edge where the slave's own pready is seen
  assign xfer_done = psel && penable && pready;
  assign wr_done   = xfer_done && pwrite;
  assign rd_done   = xfer_done && !pwrite;
  assign wr_sc     = wr_done && (paddr == OFS_STATUS_CONTROL);
  assign wr_cfg    = wr_done && (paddr == OFS_CLOCK_CONFIG);
  assign wr_mh     = wr_done && (paddr == OFS_MODULO_HIGH);
  assign wr_ml     = wr_done && (paddr == OFS_MODULO_LOW);
  assign rd_sc     = rd_done && (paddr == OFS_STATUS_CONTROL);
  assign trst      = wr_sc && pwdata[SC_TRST_BIT];
  assign soft_rst  = wr_done && (paddr == OFS_SOFT_RESET) && pwdata[SOFT_RESET_BIT];

  always_comb begin
    addr_ok = 1'b1;
    rd_mux  = 32'h0000_0000;
    case (paddr)
      OFS_STATUS_CONTROL: rd_mux[7:0] = {flag_reg, ie_reg, 1'b0, stop_reg, 4'h0};
      OFS_CLOCK_CONFIG:   rd_mux[7:0] = {2'b00, cfg_reg};
      OFS_COUNT_HIGH:     rd_mux[7:0] = cnt_reg[15:8];
      OFS_COUNT_LOW:      rd_mux[7:0] = cnt_reg[7:0];
      OFS_MODULO_HIGH:    rd_mux[7:0] = mod_reg[15:8];
      OFS_MODULO_LOW:     rd_mux[7:0] = mod_reg[7:0];
      OFS_SOFT_RESET:     rd_mux[7:0] = 8'h00;
      default:            addr_ok = 1'b0;
    endcase
  end

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !addr_ok;
      if (psel && penable && !pready && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control and configuration

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_reg <= STOP_RESET;
      ie_reg   <= 1'b0;
      cfg_reg  <= '{clock_source_select: CLOCK_SOURCE_SELECT_RESET, prescale_select: PS_RESET};
    end else if (soft_rst) begin
      stop_reg <= STOP_RESET;
      ie_reg   <= 1'b0;
      cfg_reg  <= '{clock_source_select: CLOCK_SOURCE_SELECT_RESET, prescale_select: PS_RESET};
    end else begin
      if (wr_sc) begin
        stop_reg <= pwdata[SC_STOP_BIT];
        ie_reg   <= pwdata[SC_IE_BIT];
      end
      if (wr_cfg) begin
        // counter and prescaler are left alone on a change
        cfg_reg <= clk_cfg_t'(pwdata[CFG_CLOCK_SOURCE_SELECT_LSB+1:CFG_PS_LSB]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers: fixed clock on bit 0, timer pin on bit 1

  logic [1:0] async_in;
  logic [1:0] sync1_reg;
  logic [1:0] sync2_reg;
  logic [1:0] sync3_reg;
  logic [1:0] filt_reg;
  logic [1:0] rise_reg;
  logic [1:0] fall_reg;

  assign async_in = {external_timer_clock_pin, fixed_frequency_clock};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
          sync3_reg[gi] <= 1'b0;
          filt_reg[gi]  <= 1'b0;
          rise_reg[gi]  <= 1'b0;
          fall_reg[gi]  <= 1'b0;
        end else begin
          sync1_reg[gi] <= async_in[gi];
          sync2_reg[gi] <= sync1_reg[gi];
          sync3_reg[gi] <= sync2_reg[gi];
          // a level counts only once two stages agree
          if (sync2_reg[gi] == sync3_reg[gi]) begin
            filt_reg[gi] <= sync3_reg[gi];
          end
          rise_reg[gi] <= (sync2_reg[gi] == sync3_reg[gi]) && sync3_reg[gi] && !filt_reg[gi];
          fall_reg[gi] <= (sync2_reg[gi] == sync3_reg[gi]) && !sync3_reg[gi] && filt_reg[gi];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // source select and prescaler

  logic       src_tick;
  logic [3:0] ps_eff;
  logic [8:0] ps_one;
  logic [7:0] ps_mask;
  logic [7:0] presc_reg;
  logic       count_tick;

  always_comb begin
    case (cfg_reg.clock_source_select)
      SRC_BUS:      src_tick = 1'b1;
      SRC_FIXED:    src_tick = rise_reg[0];
      SRC_PIN_FALL: src_tick = fall_reg[1];
      SRC_PIN_RISE: src_tick = rise_reg[1];
      default:      src_tick = 1'b0;
    endcase
  end

  // codes above eight saturate at divide by 256
  assign ps_eff     = (cfg_reg.prescale_select > PS_MAX) ? PS_MAX : cfg_reg.prescale_select;
  assign ps_one     = 9'h001 << ps_eff;
  assign ps_mask    = 8'(ps_one - 9'h001);
  assign count_tick = src_tick && !stop_reg && ((presc_reg & ps_mask) == ps_mask);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_reg <= 8'h00;
    end else if (trst) begin
      presc_reg <= 8'h00;
    end else if (src_tick && !stop_reg) begin
      presc_reg <= presc_reg + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // modulo write latch

  logic        dbg_wr;
  logic        mod_complete;
  logic [15:0] mod_new;

  assign dbg_wr       = debug_halt_mode && (wr_mh || wr_ml);
  assign mod_complete = !debug_halt_mode && ((wr_mh && latch_reg.lo_seen) || (wr_ml && latch_reg.hi_seen));
  assign mod_new      = {wr_mh ? pwdata[7:0] : latch_reg.hi_buf, wr_ml ? pwdata[7:0] : latch_reg.lo_buf};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_reg <= '0;
    end else if (trst || soft_rst) begin
      latch_reg.hi_seen <= 1'b0;
      latch_reg.lo_seen <= 1'b0;
    end else if (!debug_halt_mode) begin
      if (mod_complete) begin
        latch_reg.hi_seen <= 1'b0;
        latch_reg.lo_seen <= 1'b0;
      end else if (wr_mh) begin
        latch_reg.hi_buf  <= pwdata[7:0];
        latch_reg.hi_seen <= 1'b1;
      end else if (wr_ml) begin
        latch_reg.lo_buf  <= pwdata[7:0];
        latch_reg.lo_seen <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter and active modulo

  logic [15:0] top;
  logic        at_top;
  logic        wrap_evt;
  logic        imm_apply;

  // zero modulo counts the full range
  assign top       = (mod_reg == MODULO_RESET) ? COUNT_MAX : mod_reg;
  assign at_top    = (cnt_reg == top);
  assign imm_apply = mod_complete && (imm_chip_reg || imm_soft_reg);
  assign wrap_evt  = count_tick && at_top && !trst && !dbg_wr && !imm_apply;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg        <= COUNT_RESET;
      mod_reg        <= MODULO_RESET;
      pend_reg       <= MODULO_RESET;
      pend_valid_reg <= 1'b0;
      imm_chip_reg   <= 1'b1;
      imm_soft_reg   <= 1'b0;
    end else if (trst) begin
      cnt_reg        <= COUNT_RESET;
      pend_valid_reg <= 1'b0;
      if (pend_valid_reg) begin
        mod_reg <= pend_reg;
      end
    end else if (dbg_wr) begin
      // halt-mode writes skip the buffer entirely
      cnt_reg <= COUNT_RESET;
      if (wr_mh) begin
        mod_reg[15:8] <= pwdata[7:0];
      end else begin
        mod_reg[7:0] <= pwdata[7:0];
      end
    end else if (imm_apply) begin
      mod_reg        <= mod_new;
      pend_valid_reg <= 1'b0;
      imm_chip_reg   <= 1'b0;
      imm_soft_reg   <= 1'b0;
      if (imm_chip_reg) begin
        cnt_reg <= COUNT_RESET;
      end
    end else begin
      if (soft_rst) begin
        imm_soft_reg <= 1'b1;
      end
      if (mod_complete) begin
        pend_reg       <= mod_new;
        pend_valid_reg <= 1'b1;
      end
      if (wrap_evt) begin
        cnt_reg <= COUNT_RESET;
        // a pending modulo starts with the new counter cycle
        if (mod_complete) begin
          mod_reg        <= mod_new;
          pend_valid_reg <= 1'b0;
        end else if (pend_valid_reg) begin
          mod_reg        <= pend_reg;
          pend_valid_reg <= 1'b0;
        end
      end else if (count_tick) begin
        cnt_reg <= cnt_reg + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // overflow flag and interrupt

  // software must keep enable low while the flag is up; nothing here blocks it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg      <= 1'b0;
      clr_state_reg <= CLR_IDLE;
    end else if (wrap_evt) begin
      flag_reg      <= 1'b1;
      clr_state_reg <= CLR_IDLE;
    end else if (trst || soft_rst) begin
      flag_reg      <= 1'b0;
      clr_state_reg <= CLR_IDLE;
    end else begin
      case (clr_state_reg)
        CLR_IDLE: begin
          if (rd_sc && flag_reg) begin
            clr_state_reg <= CLR_ARMED;
          end
        end
        CLR_ARMED: begin
          if (wr_sc && !pwdata[SC_FLAG_BIT]) begin
            flag_reg      <= 1'b0;
            clr_state_reg <= CLR_IDLE;
          end
        end
        default: clr_state_reg <= CLR_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_irq <= 1'b0;
    end else begin
      overflow_irq <= flag_reg && ie_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic quiet;
  assign quiet = !trst && !dbg_wr && !imm_apply && !soft_rst;

  property p_free_wrap;
    (mod_reg == MODULO_RESET) && (cnt_reg == COUNT_MAX) && count_tick && quiet
      |=> (cnt_reg == COUNT_RESET) && flag_reg;
  endproperty
  a_free_wrap: assert property (p_free_wrap) else $error("free-running wrap failed");

  property p_mod_wrap;
    (mod_reg != MODULO_RESET) && (cnt_reg == mod_reg) && count_tick && quiet
      |=> (cnt_reg == COUNT_RESET) && flag_reg;
  endproperty
  a_mod_wrap: assert property (p_mod_wrap) else $error("modulo wrap failed");

  property p_increment;
    count_tick && !at_top && quiet |=> cnt_reg == $past(cnt_reg) + 16'h0001;
  endproperty
  a_increment: assert property (p_increment) else $error("counter did not increment");

  property p_no_early_flag;
    !flag_reg && !wrap_evt |=> !flag_reg;
  endproperty
  a_no_early_flag: assert property (p_no_early_flag) else $error("flag set without wrap");

  property p_stop_hold;
    stop_reg && quiet |=> $stable(cnt_reg);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stopped counter moved");

  property p_clear_needs_read;
    flag_reg && (clr_state_reg == CLR_IDLE) && !trst && !soft_rst |=> flag_reg;
  endproperty
  a_clear_needs_read: assert property (p_clear_needs_read) else $error("flag cleared without read");

  property p_set_wins;
    wrap_evt |=> flag_reg && (clr_state_reg == CLR_IDLE);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("overflow lost during clear");

  property p_trst;
    trst |=> (cnt_reg == COUNT_RESET) && !flag_reg && !latch_reg.hi_seen && !latch_reg.lo_seen;
  endproperty
  a_trst: assert property (p_trst) else $error("counter reset incomplete");

  property p_irq;
    flag_reg && ie_reg |=> overflow_irq ##1 (overflow_irq == $past(flag_reg && ie_reg));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt request wrong");

  property p_defer;
    mod_complete && !imm_apply && !trst && !wrap_evt |=> mod_reg == $past(mod_reg);
  endproperty
  a_defer: assert property (p_defer) else $error("modulo applied mid-cycle");

  property p_first_write;
    mod_complete && imm_chip_reg && !trst |=> (cnt_reg == COUNT_RESET) && (mod_reg == $past(mod_new));
  endproperty
  a_first_write: assert property (p_first_write) else $error("first modulo write not immediate");

  property p_debug_write;
    debug_halt_mode && wr_mh && !trst |=> (mod_reg[15:8] == $past(pwdata[7:0])) && (cnt_reg == COUNT_RESET);
  endproperty
  a_debug_write: assert property (p_debug_write) else $error("halt-mode write not direct");

  property p_debug_freeze;
    debug_halt_mode && !trst && !soft_rst |=> $stable(latch_reg.hi_seen) && $stable(latch_reg.lo_seen);
  endproperty
  a_debug_freeze: assert property (p_debug_freeze) else $error("latch moved in halt mode");

  c_mod_wrap:   cover property (wrap_evt && (mod_reg != MODULO_RESET));
  c_clear_seq:  cover property ((clr_state_reg == CLR_ARMED) ##[1:20] !flag_reg);
  c_dbg_write:  cover property (dbg_wr);
  c_pin_count:  cover property (count_tick && (cfg_reg.clock_source_select == SRC_PIN_RISE));

endmodule

`default_nettype wire

/* verilog/modulo_timer_pkg.sv */
// package: register map, field layout, reset values and encodings of the modulo timer
package modulo_timer_pkg;

  // register byte offsets on the apb word grid
  localparam logic [7:0] OFS_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_CLOCK_CONFIG   = 8'h04;
  localparam logic [7:0] OFS_COUNT_HIGH     = 8'h08;
  localparam logic [7:0] OFS_COUNT_LOW      = 8'h0c;
  localparam logic [7:0] OFS_MODULO_HIGH    = 8'h10;
  localparam logic [7:0] OFS_MODULO_LOW     = 8'h14;
  localparam logic [7:0] OFS_SOFT_RESET     = 8'h18;

  // status/control bit positions
  localparam int unsigned SC_FLAG_BIT = 7;
  localparam int unsigned SC_IE_BIT   = 6;
  localparam int unsigned SC_TRST_BIT = 5;
  localparam int unsigned SC_STOP_BIT = 4;
  // clock config field positions
  localparam int unsigned CFG_CLOCK_SOURCE_SELECT_LSB = 4;
  localparam int unsigned CFG_PS_LSB   = 0;
  // software reset trigger bit
  localparam int unsigned SOFT_RESET_BIT = 0;

  // reset values and limits
  localparam logic [15:0] COUNT_RESET  = 16'h0000;
  localparam logic [15:0] MODULO_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX    = 16'hffff;
  localparam logic [3:0]  PS_RESET     = 4'h0;
  localparam logic [3:0]  PS_MAX       = 4'h8;
  localparam logic        STOP_RESET   = 1'b1;

  typedef enum logic [1:0] {
    SRC_BUS      = 2'b00,
    SRC_FIXED    = 2'b01,
    SRC_PIN_FALL = 2'b10,
    SRC_PIN_RISE = 2'b11
  } clk_src_t;

  localparam clk_src_t CLOCK_SOURCE_SELECT_RESET = SRC_BUS;

  typedef struct packed {
    clk_src_t   clock_source_select;
    logic [3:0] prescale_select;
  } clk_cfg_t;

  typedef struct packed {
    logic hi_seen;
    logic lo_seen;
    logic [7:0] hi_buf;
    logic [7:0] lo_buf;
  } mod_latch_t;

  typedef enum {CLR_IDLE, CLR_ARMED} clr_state_t;

endpackage
